// [verilog/hbsfc_top.sv]
// sleep, wake-up, thermal and supply lockout control of a dual h-bridge
// assumes limit, thermal and supply comparator levels synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module hbsfc_top #(
	parameter int WAKE_CYC = hbsfc_pkg::WAKE_CYC,
	parameter int DEG_CYC = hbsfc_pkg::DEGLITCH_CYC,
	parameter int RETRY_CYC = hbsfc_pkg::RETRY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic standby_request_low,
	input wire logic supply_low_lockout,
	input wire logic thermal_trip,
	input wire logic bridge_a_input_one,
	input wire logic bridge_a_input_two,
	input wire logic bridge_b_input_one,
	input wire logic bridge_b_input_two,
	input wire logic [1:0] hs_limit,
	input wire logic [1:0] ls_limit,
	input wire logic [1:0] bridge_sense_node,
	output logic [1:0] out_one,
	output logic [1:0] out_one_oe_n,
	output logic [1:0] out_two,
	output logic [1:0] out_two_oe_n,
	output logic [1:0] chop_active,
	output logic charge_pump_en,
	output logic osc_en,
	output logic fault_flag_low,
	output logic fault_flag_low_oe_n
);
	typedef struct packed {
		hbsfc_pkg::hbsfc_mode_t mode;
		logic [hbsfc_pkg::CNT_W-1:0] cnt;
		logic [hbsfc_pkg::CNT_W-1:0] age;
		logic fault;
	} hbsfc_top_st_t;
	hbsfc_top_st_t s_q, s_d;
	// reset synchroniser kept apart: it runs on a different reset
	logic [1:0] rs_q;
	logic rst_sync_n;
	logic core_rst_n;
	logic bridge_en;
	logic [1:0] overcurrent_shutdown;
	logic [1:0] in_one;
	logic [1:0] in_two;
	assign rst_sync_n = rs_q[1];
	// sleep or lockout resets the core
	assign core_rst_n = rst_sync_n & standby_request_low & ~supply_low_lockout;
	assign in_one = {bridge_b_input_one, bridge_a_input_one};
	assign in_two = {bridge_b_input_two, bridge_a_input_two};
	// inputs act only when awake, not hot
	assign bridge_en = (s_q.mode == hbsfc_pkg::HBSFC_ACTIVE) & ~thermal_trip;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	always_comb begin
		s_d = s_q;
		case (s_q.mode)
			hbsfc_pkg::HBSFC_SLEEP: begin
				s_d.mode = hbsfc_pkg::HBSFC_WAKING;
				s_d.cnt = '0;
			end
			hbsfc_pkg::HBSFC_WAKING: begin
				// release, sleep cycle and output edge fit in the delay
				if (s_q.cnt >= hbsfc_pkg::CNT_W'(WAKE_CYC - 3)) begin
					s_d.mode = hbsfc_pkg::HBSFC_ACTIVE;
					s_d.cnt = '0;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			hbsfc_pkg::HBSFC_ACTIVE: begin
				s_d.cnt = '0;
			end
			default: begin
				s_d.mode = hbsfc_pkg::HBSFC_SLEEP;
				s_d.cnt = '0;
			end
		endcase
		s_d.fault = thermal_trip | (|overcurrent_shutdown);
		// cycles spent out of active since core release, for the wake check
		if (s_q.mode != hbsfc_pkg::HBSFC_ACTIVE && s_q.age != '1) begin
			s_d.age = s_q.age + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			s_q <= '{mode: hbsfc_pkg::HBSFC_SLEEP, cnt: '0, age: '0,
				fault: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_br
			// each bridge trips on its own
			hbsfc_bridge #(.DEG_CYC(DEG_CYC), .RETRY_CYC(RETRY_CYC)) u_br (
				.clk(clk),
				.rst_n(core_rst_n),
				.enable(bridge_en),
				.in_one(in_one[g]),
				.in_two(in_two[g]),
				.hs_limit(hs_limit[g]),
				.ls_limit(ls_limit[g]),
				.sense_over(bridge_sense_node[g]),
				.out_one(out_one[g]),
				.out_one_oe_n(out_one_oe_n[g]),
				.out_two(out_two[g]),
				.out_two_oe_n(out_two_oe_n[g]),
				.chop_active(chop_active[g]),
				.ocp_fault(overcurrent_shutdown[g])
			);
		end
	endgenerate
	// pump and clocks stop in sleep
	assign charge_pump_en = core_rst_n;
	assign osc_en = core_rst_n;
	// open drain: output always low, enable active low when pulling
	assign fault_flag_low = 1'b0;
	assign fault_flag_low_oe_n =
		~(s_q.fault | (supply_low_lockout & rst_sync_n));

	sequence s_wake_release;
		$rose(core_rst_n);
	endsequence
	a_sleep_hiz: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!standby_request_low |-> (&out_one_oe_n) && (&out_two_oe_n))
		else $error("outputs driven in sleep");
	a_sleep_pump_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!standby_request_low |-> !charge_pump_en && !osc_en)
		else $error("pump running in sleep");
	a_wake_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
		s_wake_release |-> ((&out_one_oe_n) && (&out_two_oe_n)) [*8])
		else $error("outputs changed before wake delay");
	a_wake_bound: assert property (@(posedge clk) disable iff (!core_rst_n)
		s_q.age < hbsfc_pkg::CNT_W'(WAKE_CYC))
		else $error("wake took too long");
	a_thermal_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
		thermal_trip |=> (&out_one_oe_n) && (&out_two_oe_n))
		else $error("drives during thermal trip");
	a_thermal_fault: assert property (@(posedge clk) disable iff (!core_rst_n)
		thermal_trip |=> !fault_flag_low_oe_n)
		else $error("fault not shown on thermal trip");
	a_lockout_fault: assert property (@(posedge clk) disable iff (!rst_sync_n)
		supply_low_lockout |-> !fault_flag_low_oe_n && !charge_pump_en)
		else $error("lockout not reported");
	a_ocp_fault: assert property (@(posedge clk) disable iff (!core_rst_n)
		$rose(|overcurrent_shutdown) |=> !fault_flag_low_oe_n)
		else $error("overcurrent not reported");
	a_brake_decode: assert property (@(posedge clk) disable iff (!core_rst_n)
		bridge_en && !overcurrent_shutdown[0] && bridge_a_input_one && bridge_a_input_two
		&& !thermal_trip |=> overcurrent_shutdown[0] || (!out_one_oe_n[0] && !out_one[0]
		&& !out_two[0]) || !bridge_en)
		else $error("brake decode wrong");
endmodule
`default_nettype wire

// [common/hbsfc_pkg.sv]
// constants for the bridge sleep and fault control block
// assumes a 25 MHz system clock
package hbsfc_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int WAKE_US = 1000;
	localparam int WAKE_CYC = (WAKE_US * (CLK_HZ / 1000000));
	localparam int DEGLITCH_NS = 4000;
	localparam int DEGLITCH_CYC = (DEGLITCH_NS + 39) / 40;
	localparam int RETRY_US = 1350;
	localparam int RETRY_CYC = (RETRY_US * (CLK_HZ / 1000000));
	localparam int CNT_W = 16;
	localparam logic [1:0] IN_COAST = 2'h0;
	localparam logic [1:0] IN_REV = 2'h1;
	localparam logic [1:0] IN_FWD = 2'h2;
	localparam logic [1:0] IN_BRAKE = 2'h3;
	typedef enum logic [1:0] {
		HBSFC_RUN,
		HBSFC_TRIPPED
	} hbsfc_ocp_st_t;
	typedef enum logic [1:0] {
		HBSFC_SLEEP,
		HBSFC_WAKING,
		HBSFC_ACTIVE
	} hbsfc_mode_t;
endpackage

// [verilog/hbsfc_bridge.sv]
// one h-bridge: input decode, chopping and overcurrent shutdown with retry
// assumes the top holds it in reset while sleeping or under supply lockout
`timescale 1ns/1ps
`default_nettype none
module hbsfc_bridge #(
	parameter int DEG_CYC = hbsfc_pkg::DEGLITCH_CYC,
	parameter int RETRY_CYC = hbsfc_pkg::RETRY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic in_one,
	input wire logic in_two,
	input wire logic hs_limit,
	input wire logic ls_limit,
	input wire logic sense_over,
	output logic out_one,
	output logic out_one_oe_n,
	output logic out_two,
	output logic out_two_oe_n,
	output logic chop_active,
	output logic ocp_fault
);
	typedef struct packed {
		hbsfc_pkg::hbsfc_ocp_st_t st;
		logic [hbsfc_pkg::CNT_W-1:0] cnt;
		logic o1;
		logic o2;
		logic oe1_n;
		logic oe2_n;
		logic chop;
	} hbsfc_br_t;
	hbsfc_br_t s_q, s_d;
	logic limit;
	assign limit = hs_limit | ls_limit;
	always_comb begin
		s_d = s_q;
		s_d.chop = enable & sense_over;
		case (s_q.st)
			hbsfc_pkg::HBSFC_RUN: begin
				if (limit && enable) begin
					if (s_q.cnt >= hbsfc_pkg::CNT_W'(DEG_CYC - 1)) begin
						s_d.st = hbsfc_pkg::HBSFC_TRIPPED;
						s_d.cnt = '0;
					end else begin
						s_d.cnt = s_q.cnt + 1'b1;
					end
				end else begin
					s_d.cnt = '0;
				end
			end
			hbsfc_pkg::HBSFC_TRIPPED: begin
				if (s_q.cnt >= hbsfc_pkg::CNT_W'(RETRY_CYC - 1)) begin
					s_d.st = hbsfc_pkg::HBSFC_RUN;
					s_d.cnt = '0;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			default: begin
				s_d.st = hbsfc_pkg::HBSFC_RUN;
				s_d.cnt = '0;
			end
		endcase
		// decode; chopping forces slow decay
		s_d.o1 = 1'b0;
		s_d.o2 = 1'b0;
		s_d.oe1_n = 1'b1;
		s_d.oe2_n = 1'b1;
		if (enable && s_d.st == hbsfc_pkg::HBSFC_RUN) begin
			case ({in_one, in_two})
				hbsfc_pkg::IN_COAST: begin
					s_d.oe1_n = 1'b1;
				end
				hbsfc_pkg::IN_REV: begin
					s_d.o2 = ~s_d.chop;
					s_d.oe1_n = 1'b0;
					s_d.oe2_n = 1'b0;
				end
				hbsfc_pkg::IN_FWD: begin
					s_d.o1 = ~s_d.chop;
					s_d.oe1_n = 1'b0;
					s_d.oe2_n = 1'b0;
				end
				default: begin
					s_d.oe1_n = 1'b0;
					s_d.oe2_n = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: hbsfc_pkg::HBSFC_RUN, cnt: '0, o1: 1'b0, o2: 1'b0,
				oe1_n: 1'b1, oe2_n: 1'b1, chop: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end
	assign out_one = s_q.o1;
	assign out_two = s_q.o2;
	assign out_one_oe_n = s_q.oe1_n;
	assign out_two_oe_n = s_q.oe2_n;
	assign chop_active = s_q.chop;
	assign ocp_fault = (s_q.st == hbsfc_pkg::HBSFC_TRIPPED);

	a_trip_outputs_off: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ocp_fault) |-> out_one_oe_n && out_two_oe_n)
		else $error("tripped bridge still drives");
	a_retry_length: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ocp_fault) |-> ocp_fault [*8])
		else $error("retry period ended early");
endmodule
`default_nettype wire

// [bench/hbsfc_host.sv]
// host controller model: drives the input pairs and the sleep pin
// assumes the bench gives the codes; the fault line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module hbsfc_host (
	input wire logic [1:0] code_a,
	input wire logic [1:0] code_b,
	input wire logic sleep_cmd,
	input wire logic fault_flag_low,
	input wire logic fault_flag_low_oe_n,
	output logic standby_request_low,
	output logic [3:0] pins,
	output logic fault_seen
);
	assign standby_request_low = ~sleep_cmd;
	// codes may stand at any time, no ordering kept
	assign pins = {code_b, code_a};
	assign fault_seen = fault_flag_low_oe_n ? 1'h1 : fault_flag_low;
endmodule
`default_nettype wire

// [bench/test_hbsfc_top.sv]
// self-checking bench of the bridge sleep and fault control
// assumes shortened delay counts and the host model on the pins
`timescale 1ns/1ps
`default_nettype none
module test_hbsfc_top;
	localparam int WK = 20;
	localparam int DG = 4;
	localparam int RT = 20;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sleep_cmd = 1'h1;
	logic lock = 1'h0;
	logic hot = 1'h0;
	logic [1:0] ca = 2'h0;
	logic [1:0] cb = 2'h0;
	logic [1:0] hs = 2'h0;
	logic [1:0] ls = 2'h0;
	logic [1:0] sns = 2'h0;
	wire stby;
	wire fs;
	wire [3:0] p;
	logic [1:0] o1, o1n, o2, o2n, chop;
	logic cp, osc, ff, ffn;
	int fails = 0;
	int compares = 0;
	logic [31:0] rs = 32'hBBA9;
	logic [8:0] q[$];
	wire [8:0] seen;
	event smp;
	// driven pins only; an undriven pin shows its value as 0
	assign seen = {fs, o1n[1], o2n[1], o1[1] & ~o1n[1], o2[1] & ~o2n[1],
		o1n[0], o2n[0], o1[0] & ~o1n[0], o2[0] & ~o2n[0]};
	always #20 clk = ~clk;
	hbsfc_host hbsfc_host_inst (.code_a(ca), .code_b(cb),
		.sleep_cmd(sleep_cmd), .fault_flag_low(ff),
		.fault_flag_low_oe_n(ffn), .standby_request_low(stby),
		.pins(p), .fault_seen(fs));
	hbsfc_top #(.WAKE_CYC(WK), .DEG_CYC(DG), .RETRY_CYC(RT))
		hbsfc_top_inst (
		.clk(clk), .rst_n(rst_n), .standby_request_low(stby),
		.supply_low_lockout(lock), .thermal_trip(hot),
		.bridge_a_input_one(p[1]), .bridge_a_input_two(p[0]),
		.bridge_b_input_one(p[3]), .bridge_b_input_two(p[2]),
		.hs_limit(hs), .ls_limit(ls), .bridge_sense_node(sns),
		.out_one(o1), .out_one_oe_n(o1n), .out_two(o2), .out_two_oe_n(o2n),
		.chop_active(chop), .charge_pump_en(cp), .osc_en(osc),
		.fault_flag_low(ff), .fault_flag_low_oe_n(ffn));
	// {oe1_n, oe2_n, out1, out2} of one bridge
	function automatic logic [3:0] dec(input logic [1:0] c);
		case (c)
			2'h0: dec = 4'hC;
			2'h1: dec = 4'h1;
			2'h2: dec = 4'h2;
			default: dec = 4'h0;
		endcase
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	task automatic check(input logic [8:0] s, input logic [8:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic drv(input logic [1:0] a, input logic [1:0] b);
		@(posedge clk);
		ca <= a;
		cb <= b;
	endtask
	task automatic note(input logic f, input logic [3:0] b,
		input logic [3:0] a);
		@(negedge clk);
		q.push_back({f, b, a});
		->smp;
	endtask
	always @(smp) check(seen, q.pop_front());
	initial begin
		#(40 * 4000);
		fails++;
		summarize();
	end
	initial begin
		cyc(10);
		rst_n <= 1'h1;
		repeat (8) begin
			rs = xs(rs);
			drv(rs[1:0], rs[3:2]);
			hs <= rs[5:4];
		end
		note(1'h1, 4'hC, 4'hC);
		check({8'h0, cp | osc}, 9'h0);
		@(posedge clk);
		hs <= 2'h0;
		ca <= 2'h2;
		cb <= 2'h1;
		sleep_cmd <= 1'h0;
		cyc(WK - 4);
		note(1'h1, 4'hC, 4'hC);
		cyc(8);
		note(1'h1, dec(2'h1), dec(2'h2));
		check({8'h0, cp & osc}, 9'h1);
		for (int i = 0; i < 16; i++) begin
			drv(i[1:0], i[3:2]);
			cyc(2);
			note(1'h1, dec(i[3:2]), dec(i[1:0]));
		end
		repeat (8) begin
			rs = xs(rs);
			drv(rs[1:0], rs[3:2]);
			cyc(2);
			note(1'h1, dec(rs[3:2]), dec(rs[1:0]));
		end
		drv(2'h2, 2'h2);
		sns <= 2'h1;
		cyc(3);
		note(1'h1, dec(2'h2), 4'h0);
		check({7'h0, chop}, 9'h1);
		for (int k = 0; k < 2; k++) begin
			logic [3:0] exp_b;
			logic [3:0] exp_a;
			exp_b = k[0] ? 4'hC : 4'h2;
			exp_a = k[0] ? 4'h2 : 4'hC;
			@(posedge clk);
			sns <= 2'h0;
			hs <= k[0] ? 2'h0 : 2'h1;
			ls <= k[0] ? 2'h2 : 2'h0;
			cyc(DG + 3);
			note(1'h0, exp_b, exp_a);
			cyc(RT - 8);
			note(1'h0, exp_b, exp_a);
			cyc(DG + 9);
			note(1'h0, exp_b, exp_a);
			@(posedge clk);
			hs <= 2'h0;
			ls <= 2'h0;
			cyc(RT + 4);
			note(1'h1, 4'h2, 4'h2);
		end
		@(posedge clk);
		hot <= 1'h1;
		cyc(3);
		note(1'h0, 4'hC, 4'hC);
		@(posedge clk);
		hot <= 1'h0;
		cyc(3);
		note(1'h1, 4'h2, 4'h2);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			lock <= ~k[0];
			sleep_cmd <= k[0];
			cyc(3);
			note(k[0], 4'hC, 4'hC);
			check({8'h0, cp | osc}, 9'h0);
			@(posedge clk);
			lock <= 1'h0;
			sleep_cmd <= 1'h0;
			cyc(WK - 4);
			note(1'h1, 4'hC, 4'hC);
			cyc(10);
			note(1'h1, 4'h2, 4'h2);
		end
		summarize();
	end
endmodule
`default_nettype wire
